// [rtl/amlc_bank.v]
// Mode and level control register bank with step timers and threshold decode
`timescale 1ns/1ps
`include "amlc_regs.vh"
module amlc_bank #(
    parameter CNT_W = 24,
    parameter RELEASE_BASE_CYC = `AMLC_RELEASE_BASE_CYC,
    parameter ATTACK_BASE_CYC = `AMLC_ATTACK_BASE_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWriteData,
    output reg [7:0] regReadData_reg,
    output reg [1:0] edgeRateCode_reg,
    output reg overcurrentAutoRestart_reg,
    output reg overtempAutoRestart_reg,
    output reg rightToBothMix_reg,
    output reg leftToBothMix_reg,
    output reg leftOutFromRight_reg,
    output reg rightOutFromLeft_reg,
    output reg [2:0] releaseRateCode_reg,
    output reg [2:0] attackRateCode_reg,
    output reg levelControlEnable_reg,
    output reg gainWriteLock_reg,
    output reg [1:0] dynamicsCurve_reg,
    output reg thresholdReferenceSelect_reg,
    output reg [3:0] limitThresholdCode_reg,
    output reg [8:0] thresholdLevel_reg,
    output wire releaseStepTick,
    output wire attackStepTick
);
    reg [7:0] mode_reg;
    reg [7:0] timing_reg;
    reg [7:0] config_reg;
    reg [7:0] mode_next;
    reg [7:0] timing_next;
    reg [7:0] config_next;
    reg [7:0] readData_next;
    reg [8:0] thresholdLevel_next;
    wire writeMode;
    wire writeTiming;
    wire writeConfig;
    // Field resets cut from the stored images so the two cannot drift apart
    localparam [7:0] RST_MODE = `AMLC_RST_MODE;
    localparam [7:0] RST_TIMING = `AMLC_RST_TIMING;
    localparam [7:0] RST_CONFIG = `AMLC_RST_CONFIG;

    // Supply tracking: percent of supply
    function [8:0] pctOf;
        input [3:0] code;
        begin
            case (code)
                4'h0: pctOf = 9'h040;
                4'h1: pctOf = 9'h042;
                4'h2: pctOf = 9'h043;
                4'h3: pctOf = 9'h045;
                4'h4: pctOf = 9'h046;
                4'h5: pctOf = 9'h048;
                4'h6: pctOf = 9'h04a;
                4'h7: pctOf = 9'h04c;
                4'h8: pctOf = 9'h04e;
                4'h9: pctOf = 9'h050;
                4'ha: pctOf = 9'h053;
                4'hb: pctOf = 9'h055;
                4'hc: pctOf = 9'h058;
                4'hd: pctOf = 9'h05a;
                4'he: pctOf = 9'h05d;
                default: pctOf = 9'h060;
            endcase
        end
    endfunction

    // Fixed power: limit in units of 10 mV
    function [8:0] voltOf;
        input [3:0] code;
        begin
            case (code)
                4'h0: voltOf = 9'h103;
                4'h1: voltOf = 9'h10f;
                4'h2: voltOf = 9'h11b;
                4'h3: voltOf = 9'h127;
                4'h4: voltOf = 9'h132;
                4'h5: voltOf = 9'h13e;
                4'h6: voltOf = 9'h14a;
                4'h7: voltOf = 9'h156;
                4'h8: voltOf = 9'h162;
                4'h9: voltOf = 9'h16d;
                4'ha: voltOf = 9'h179;
                4'hb: voltOf = 9'h185;
                4'hc: voltOf = 9'h191;
                4'hd: voltOf = 9'h19d;
                4'he: voltOf = 9'h1a9;
                default: voltOf = 9'h1b4;
            endcase
        end
    endfunction

    function isAddr;
        input [7:0] addr;
        input [7:0] target;
        begin
            isAddr = (addr == target);
        end
    endfunction

    // One write decode per register
    assign writeMode = regWrite && isAddr(regAddr, `AMLC_ADDR_MODE);
    assign writeTiming = regWrite && isAddr(regAddr, `AMLC_ADDR_TIMING);
    assign writeConfig = regWrite && isAddr(regAddr, `AMLC_ADDR_CONFIG);

    always @* begin
        mode_next = mode_reg;
        timing_next = timing_reg;
        config_next = config_reg;
        if (writeMode) begin
            mode_next = regWriteData & `AMLC_USED_MASK;
        end
        if (writeTiming) begin
            timing_next = regWriteData & `AMLC_USED_MASK;
        end
        if (writeConfig) begin
            config_next = regWriteData;
        end
    end

    // Follows pending config so it lines up with the code outputs
    always @* begin
        if (config_next[`AMLC_CFG_REF_BIT]) begin
            thresholdLevel_next = voltOf(config_next[`AMLC_CFG_THR_HI:`AMLC_CFG_THR_LO]);
        end else begin
            thresholdLevel_next = pctOf(config_next[`AMLC_CFG_THR_HI:`AMLC_CFG_THR_LO]);
        end
    end

    always @* begin
        readData_next = 8'h00;
        if (isAddr(regAddr, `AMLC_ADDR_MODE)) begin
            readData_next = mode_reg;
        end else if (isAddr(regAddr, `AMLC_ADDR_TIMING)) begin
            readData_next = timing_reg;
        end else if (isAddr(regAddr, `AMLC_ADDR_CONFIG)) begin
            readData_next = config_reg;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= `AMLC_RST_MODE;
            timing_reg <= `AMLC_RST_TIMING;
            config_reg <= `AMLC_RST_CONFIG;
            regReadData_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            timing_reg <= timing_next;
            config_reg <= config_next;
            regReadData_reg <= readData_next;
        end
    end

    // Outputs mirror next state so they line up with the stored fields
    always @(posedge ref_clk) begin
        if (rst) begin
            edgeRateCode_reg <= RST_MODE[`AMLC_MODE_EDGE_HI:`AMLC_MODE_EDGE_LO];
            overcurrentAutoRestart_reg <= RST_MODE[`AMLC_MODE_OC_BIT];
            overtempAutoRestart_reg <= RST_MODE[`AMLC_MODE_OT_BIT];
            rightToBothMix_reg <= RST_MODE[`AMLC_MODE_R2B_BIT];
            leftToBothMix_reg <= RST_MODE[`AMLC_MODE_L2B_BIT];
            leftOutFromRight_reg <= 1'b0;
            rightOutFromLeft_reg <= 1'b0;
            releaseRateCode_reg <= RST_TIMING[`AMLC_TIM_REL_HI:`AMLC_TIM_REL_LO];
            attackRateCode_reg <= RST_TIMING[`AMLC_TIM_ATK_HI:`AMLC_TIM_ATK_LO];
            levelControlEnable_reg <= RST_CONFIG[`AMLC_CFG_EN_BIT];
            gainWriteLock_reg <= RST_CONFIG[`AMLC_CFG_EN_BIT];
            dynamicsCurve_reg <= RST_CONFIG[`AMLC_CFG_CURVE_HI:`AMLC_CFG_CURVE_LO];
            thresholdReferenceSelect_reg <= RST_CONFIG[`AMLC_CFG_REF_BIT];
            limitThresholdCode_reg <= RST_CONFIG[`AMLC_CFG_THR_HI:`AMLC_CFG_THR_LO];
            thresholdLevel_reg <= pctOf(RST_CONFIG[`AMLC_CFG_THR_HI:`AMLC_CFG_THR_LO]);
        end else begin
            edgeRateCode_reg <= mode_next[`AMLC_MODE_EDGE_HI:`AMLC_MODE_EDGE_LO];
            overcurrentAutoRestart_reg <= mode_next[`AMLC_MODE_OC_BIT];
            overtempAutoRestart_reg <= mode_next[`AMLC_MODE_OT_BIT];
            rightToBothMix_reg <= mode_next[`AMLC_MODE_R2B_BIT];
            leftToBothMix_reg <= mode_next[`AMLC_MODE_L2B_BIT];
            // Both mix bits set: left input wins on both outputs
            leftOutFromRight_reg <= mode_next[`AMLC_MODE_R2B_BIT] & ~mode_next[`AMLC_MODE_L2B_BIT];
            rightOutFromLeft_reg <= mode_next[`AMLC_MODE_L2B_BIT];
            releaseRateCode_reg <= timing_next[`AMLC_TIM_REL_HI:`AMLC_TIM_REL_LO];
            attackRateCode_reg <= timing_next[`AMLC_TIM_ATK_HI:`AMLC_TIM_ATK_LO];
            levelControlEnable_reg <= config_next[`AMLC_CFG_EN_BIT];
            // Gain bank outside must drop host gain writes while this is high
            gainWriteLock_reg <= config_next[`AMLC_CFG_EN_BIT];
            dynamicsCurve_reg <= config_next[`AMLC_CFG_CURVE_HI:`AMLC_CFG_CURVE_LO];
            thresholdReferenceSelect_reg <= config_next[`AMLC_CFG_REF_BIT];
            limitThresholdCode_reg <= config_next[`AMLC_CFG_THR_HI:`AMLC_CFG_THR_LO];
            thresholdLevel_reg <= thresholdLevel_next;
        end
    end

    // Timers idle while level control is off to save toggling
    amlc_step_timer #(
        .CNT_W(CNT_W),
        .BASE_CYC(RELEASE_BASE_CYC)
    ) releaseTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(levelControlEnable_reg),
        .rateCode(releaseRateCode_reg),
        .stepTick_reg(releaseStepTick)
    );

    amlc_step_timer #(
        .CNT_W(CNT_W),
        .BASE_CYC(ATTACK_BASE_CYC)
    ) attackTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(levelControlEnable_reg),
        .rateCode(attackRateCode_reg),
        .stepTick_reg(attackStepTick)
    );
endmodule

// [rtl/amlc_regs.vh]
// Register map, fields, reset values and step timing for the amplifier mode and level control bank
// Function
// - Two-bit edge rate field: 00 normal after reset, higher codes give slower edges.
// - Overcurrent and overtemperature restart enables, bits 3 and 2, reset to one.
// - Right-to-both mix bit 1 sends right input to both outputs unless bit 0 is also set; resets clear.
// - Left-to-both mix bit 0 sends left input to both outputs; resets clear.
// - Release step time doubles per code from 4 ms to 512 ms; default 101.
// - Attack step time doubles per code from 32 us to 4 ms; default 011.
// - Bit 7 of config register enables level control; resets to zero.
// - Curve field bits 6:5 picks limiter or three compression modes; default 10.
// - Bit 4 picks threshold reference: 0 supply tracking (default), 1 fixed power.
// - Threshold code bits 3:0 select level threshold; resets to 1011.
// - While level control is enabled, host writes to channel gain bits are ignored.
// - Threshold code maps to supply percent or absolute voltage; 1011 is 85 or 3.89.
`ifndef AMLC_REGS_VH
`define AMLC_REGS_VH
`define AMLC_ADDR_MODE 8'h02
`define AMLC_ADDR_TIMING 8'h03
`define AMLC_ADDR_CONFIG 8'h04
`define AMLC_RST_MODE 8'h0c
`define AMLC_RST_TIMING 8'h2b
`define AMLC_RST_CONFIG 8'h4b
`define AMLC_MODE_EDGE_HI 5
`define AMLC_MODE_EDGE_LO 4
`define AMLC_MODE_OC_BIT 3
`define AMLC_MODE_OT_BIT 2
`define AMLC_MODE_R2B_BIT 1
`define AMLC_MODE_L2B_BIT 0
`define AMLC_USED_MASK 8'h3f
`define AMLC_TIM_REL_HI 5
`define AMLC_TIM_REL_LO 3
`define AMLC_TIM_ATK_HI 2
`define AMLC_TIM_ATK_LO 0
`define AMLC_CFG_EN_BIT 7
`define AMLC_CFG_CURVE_HI 6
`define AMLC_CFG_CURVE_LO 5
`define AMLC_CFG_REF_BIT 4
`define AMLC_CFG_THR_HI 3
`define AMLC_CFG_THR_LO 0
`define AMLC_CLK_MHZ 20
`define AMLC_RELEASE_BASE_US 4000
`define AMLC_ATTACK_BASE_US 32
`define AMLC_RELEASE_BASE_CYC (`AMLC_RELEASE_BASE_US * `AMLC_CLK_MHZ)
`define AMLC_ATTACK_BASE_CYC (`AMLC_ATTACK_BASE_US * `AMLC_CLK_MHZ)
`endif

// [rtl/amlc_step_timer.v]
// Step tick generator whose period is a base count doubled per rate code
`timescale 1ns/1ps
module amlc_step_timer #(
    parameter CNT_W = 24,
    parameter BASE_CYC = 640
) (
    input wire ref_clk,
    input wire rst,
    input wire run,
    input wire [2:0] rateCode,
    output reg stepTick_reg
);
    reg [CNT_W-1:0] count_reg;
    wire [CNT_W-1:0] baseCyc = BASE_CYC[CNT_W-1:0];
    wire [CNT_W-1:0] period = baseCyc << rateCode;
    // Compare with >= so a shortened period after a code change ends at once
    wire wrap = (count_reg >= period - {{(CNT_W-1){1'b0}}, 1'b1});

    always @(posedge ref_clk) begin
        if (rst || !run) begin
            count_reg <= {CNT_W{1'b0}};
            stepTick_reg <= 1'b0;
        end else if (wrap) begin
            count_reg <= {CNT_W{1'b0}};
            stepTick_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            stepTick_reg <= 1'b0;
        end
    end
endmodule

// [dv/amlc_host.sv]
// Host model driving the register strobe, address and data port
`timescale 1ns/1ps
module amlc_host (
    input wire ref_clk,
    output logic regWrite,
    output logic [7:0] regAddr,
    output logic [7:0] regWriteData,
    input wire [7:0] regReadData_reg
);
    initial begin
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWriteData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        // Released data shows the inverse, so a stale copy cannot pass
        regWriteData <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        @(posedge ref_clk);
        #1;
        d = regReadData_reg;
    endtask
    // Needed once restart is off; lands outside this bank
    task automatic clear_fault();
        wr(8'h07, 8'h00);
    endtask
endmodule

// [dv/amlc_bank_properties.sv]
// Port assertions for the mode and level control bank
`timescale 1ns/1ps
module amlc_bank_properties (
    input wire ref_clk,
    input wire rst,
    input wire regWrite,
    input wire [7:0] regAddr,
    input wire [7:0] regWriteData,
    input wire [7:0] regReadData_reg,
    input wire [1:0] edgeRateCode_reg,
    input wire overcurrentAutoRestart_reg,
    input wire overtempAutoRestart_reg,
    input wire rightToBothMix_reg,
    input wire leftToBothMix_reg,
    input wire leftOutFromRight_reg,
    input wire rightOutFromLeft_reg,
    input wire [2:0] releaseRateCode_reg,
    input wire [2:0] attackRateCode_reg,
    input wire levelControlEnable_reg,
    input wire gainWriteLock_reg,
    input wire [1:0] dynamicsCurve_reg,
    input wire thresholdReferenceSelect_reg,
    input wire [3:0] limitThresholdCode_reg,
    input wire [8:0] thresholdLevel_reg,
    input wire releaseStepTick,
    input wire attackStepTick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sWr(a);
        regWrite && regAddr == a;
    endsequence
    AST_MODE_WR: assert property (sWr(8'h02) |=>
        {2'b00, edgeRateCode_reg, overcurrentAutoRestart_reg, overtempAutoRestart_reg, rightToBothMix_reg,
        leftToBothMix_reg} == ($past(regWriteData) & 8'h3f)) else $error("mode fields wrong");
    AST_TIM_WR: assert property (sWr(8'h03) |=>
        {2'b00, releaseRateCode_reg, attackRateCode_reg} == ($past(regWriteData) & 8'h3f)) else $error("timing wrong");
    AST_CFG_WR: assert property (sWr(8'h04) |=> {levelControlEnable_reg, dynamicsCurve_reg,
        thresholdReferenceSelect_reg, limitThresholdCode_reg} == $past(regWriteData)) else $error("config wrong");
    AST_LOCK: assert property (gainWriteLock_reg == levelControlEnable_reg) else $error("lock wrong");
    AST_MIX: assert property (rightOutFromLeft_reg == leftToBothMix_reg &&
        leftOutFromRight_reg == (rightToBothMix_reg && !leftToBothMix_reg)) else $error("mix routing wrong");
    AST_THR: assert property (limitThresholdCode_reg == 4'hb |->
        thresholdLevel_reg == (thresholdReferenceSelect_reg ? 9'h185 : 9'h055)) else $error("threshold wrong");
    AST_UPPER_RD: assert property ((regAddr == 8'h02 || regAddr == 8'h03) |=>
        regReadData_reg[7:6] == 2'b00) else $error("upper bits not zero");
    AST_TICK_PULSE: assert property (attackStepTick |=> !attackStepTick) else $error("tick too long");
    AST_TICK_OFF: assert property (!levelControlEnable_reg && !$past(levelControlEnable_reg) &&
        !$past(levelControlEnable_reg, 2) |-> !attackStepTick && !releaseStepTick) else $error("tick while off");
endmodule
bind amlc_bank amlc_bank_properties u_props (.*);

// [dv/testbench.sv]
// Self-checking bench for the mode and level control bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errTotal++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    wire regWrite;
    wire [7:0] regAddr;
    wire [7:0] regWriteData;
    wire [7:0] rdData;
    int errTotal = 0;
    int checks = 0;
    logic [7:0] dflt [3] = '{8'h0c, 8'h2b, 8'h4b};
    amlc_host u_host (.ref_clk(ref_clk), .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
        .regReadData_reg(rdData));
    // Short step bases keep the timer checks within a few cycles
    amlc_bank #(.RELEASE_BASE_CYC(8), .ATTACK_BASE_CYC(2)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData_reg(rdData),
        .edgeRateCode_reg(), .overcurrentAutoRestart_reg(), .overtempAutoRestart_reg(), .rightToBothMix_reg(),
        .leftToBothMix_reg(), .leftOutFromRight_reg(), .rightOutFromLeft_reg(), .releaseRateCode_reg(),
        .attackRateCode_reg(), .levelControlEnable_reg(), .gainWriteLock_reg(), .dynamicsCurve_reg(),
        .thresholdReferenceSelect_reg(), .limitThresholdCode_reg(), .thresholdLevel_reg(),
        .releaseStepTick(), .attackStepTick());
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic defaults();
        logic [7:0] d;
        logic [23:0] o;
        for (int i = 0; i < 3; i++) begin
            u_host.rd(8'(2 + i), d);
            `CHK("default", dflt[i], d)
        end
        o = {2'b00, u_dut.edgeRateCode_reg, u_dut.overcurrentAutoRestart_reg, u_dut.overtempAutoRestart_reg,
            u_dut.rightToBothMix_reg, u_dut.leftToBothMix_reg, 2'b00, u_dut.releaseRateCode_reg,
            u_dut.attackRateCode_reg, u_dut.levelControlEnable_reg, u_dut.dynamicsCurve_reg,
            u_dut.thresholdReferenceSelect_reg, u_dut.limitThresholdCode_reg};
        `CHK("fieldDefaults", {dflt[0], dflt[1], dflt[2]}, o)
        o = {19'h00000, u_dut.gainWriteLock_reg, u_dut.leftOutFromRight_reg, u_dut.rightOutFromLeft_reg,
            u_dut.releaseStepTick, u_dut.attackStepTick};
        `CHK("routeDefaults", 24'h000000, o)
    endtask
    task automatic gap(input logic rel, output int n);
        int k;
        k = 0;
        n = 0;
        while (k < 2 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
            if ((rel ? u_dut.releaseStepTick : u_dut.attackStepTick) === 1'b1) begin
                k++;
                if (k == 1) n = 0;
            end
        end
        if (k < 2) begin
            errTotal++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        errTotal++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] d;
        int n;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        defaults();
        `CHK("thrLevel", 9'h055, u_dut.thresholdLevel_reg)
        for (int i = 0; i < 2; i++) begin
            u_host.wr(8'(2 + i), 8'hff);
            u_host.rd(8'(2 + i), d);
            `CHK("upper", 8'h3f, d)
        end
        for (int m = 0; m < 4; m++) begin
            u_host.wr(8'h02, 8'(m * 17));
            `CHK("edge", 2'(m), u_dut.edgeRateCode_reg)
            `CHK("restart", 2'b00, {u_dut.overcurrentAutoRestart_reg, u_dut.overtempAutoRestart_reg})
            `CHK("mix", {m == 2, m[0]}, {u_dut.leftOutFromRight_reg, u_dut.rightOutFromLeft_reg})
        end
        u_host.clear_fault();
        u_host.rd(8'h02, d);
        `CHK("modeKept", 8'h33, d)
        for (int c = 0; c < 4; c++) begin
            u_host.wr(8'h04, 8'(c * 32 + 27));
            `CHK("curve", 2'(c), u_dut.dynamicsCurve_reg)
            `CHK("limit", 9'h185, u_dut.thresholdLevel_reg)
        end
        u_host.wr(8'h03, 8'h01);
        u_host.wr(8'h04, 8'h80);
        `CHK("lock", 1'b1, u_dut.gainWriteLock_reg)
        `CHK("lowestPct", 9'h040, u_dut.thresholdLevel_reg)
        gap(1'b0, n);
        `CHK("attackGap", 32'd4, n)
        gap(1'b1, n);
        `CHK("releaseGap", 32'd8, n)
        // Reset in mid-run must restore the register, field, routing and tick defaults
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        defaults();
        tally_and_finish();
    end
endmodule
